// ==== rtl/tape_seq_map.svh ====
`ifndef TAPE_SEQ_MAP_SVH
`define TAPE_SEQ_MAP_SVH

// function codes carried in parameter block byte 11
`define FN_SPACE_FWD    8'h12
`define FN_WRITE_FMARK  8'h14
`define FN_ERASE        8'h17
`define FN_LOAD         8'h18
`define FN_TAPE_RESET   8'h1c
`define FN_RETENSION    8'h1d
`define FN_READ_STATUS  8'h1e
`define FN_TERMINATE    8'h1f

// parameter block byte positions
`define PB_DEV_LO       4'h8
`define PB_DEV_HI       4'h9
`define PB_UNIT         4'ha
`define PB_FUNC         4'hb

// operation status byte fields
`define OSB_SUM_LSB     0
`define OSB_UNIT_LSB    4
`define OSB_HARD_BIT    6
`define OSB_ERR_BIT     7

// summary codes
`define SUM_OK          4'h0
`define SUM_BAD_FUNC    4'h1
`define SUM_OFFLINE     4'h2

`endif

// ==== rtl/tape_seq_pkg.sv ====
package tape_seq_pkg;

  typedef enum logic [3:0] {
    MOT_NONE      = 4'h0,
    MOT_SPACE_FM  = 4'h1,
    MOT_WRITE_FM  = 4'h2,
    MOT_ERASE     = 4'h3,
    MOT_LOAD_BOT  = 4'h4,
    MOT_INIT      = 4'h5,
    MOT_RETENSION = 4'h6,
    MOT_REWIND    = 4'h7,
    MOT_STATUS    = 4'h8
  } motion_t;

  typedef struct packed {
    logic [15:0] device;
    logic [1:0]  unit;
    logic [7:0]  func;
    logic        suppress;
  } cmd_t;

  typedef struct packed {
    logic        valid;
    motion_t     motion;
    logic [1:0]  unit;
    logic        offline;
  } tape_req_t;

  typedef struct packed {
    logic        done;
    logic [1:0]  unit;
    logic        hard_err;
    logic        soft_err;
    logic [95:0] status;
  } tape_rsp_t;

endpackage : tape_seq_pkg

// ==== rtl/tape_cmd_decode.sv ====
`timescale 1ns/1ns
`include "tape_seq_map.svh"
module tape_cmd_decode
  import tape_seq_pkg::*;
(
  input  wire logic [7:0] func,
  input  wire logic       writing,
  input  wire logic       reading,
  output motion_t         motion,
  output logic            offline,
  output logic            legal
);
  always_comb begin
    motion  = MOT_NONE;
    offline = 1'b0;
    legal   = 1'b1;
    case (func)
      `FN_SPACE_FWD: begin
        motion  = MOT_SPACE_FM;
        offline = 1'b1;
      end
      `FN_WRITE_FMARK: motion = MOT_WRITE_FM;
      `FN_ERASE: begin
        motion  = MOT_ERASE;
        offline = 1'b1;
      end
      `FN_LOAD:        motion = MOT_LOAD_BOT;
      `FN_TAPE_RESET:  motion = MOT_INIT;
      `FN_RETENSION: begin
        motion  = MOT_RETENSION;
        offline = 1'b1;
      end
      `FN_READ_STATUS: motion = MOT_STATUS;
      `FN_TERMINATE: begin
        // a write gets a closing mark; an aborted read goes home
        if (writing)
          motion = MOT_WRITE_FM;
        else if (reading)
          motion = MOT_REWIND;
        else
          motion = MOT_NONE;
      end
      default: legal = 1'b0;
    endcase
  end
endmodule : tape_cmd_decode

// ==== rtl/status_byte_pack.sv ====
`timescale 1ns/1ns
`include "tape_seq_map.svh"
module status_byte_pack (
  input  wire logic [3:0] summary,
  input  wire logic [1:0] unit,
  input  wire logic       hard_err,
  input  wire logic       soft_err,
  output logic [7:0]      osb
);
  always_comb begin
    osb                                 = 8'h00;
    osb[`OSB_SUM_LSB +: 4]              = summary;
    osb[`OSB_UNIT_LSB +: 2]             = unit;
    osb[`OSB_HARD_BIT]                  = hard_err;
    osb[`OSB_ERR_BIT]                   = hard_err | soft_err;
  end
endmodule : status_byte_pack

// ==== rtl/tape_command_sequencer.sv ====
`timescale 1ns/1ns
`include "tape_seq_map.svh"
module tape_command_sequencer
  import tape_seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire cmd_t        cmd,            // fields from host
  input  wire logic        cmd_start,
  output logic             cmd_ready,
  input  wire logic        data_write,     // host write-data in progress
  input  wire logic        data_read,      // host read-data in progress
  input  wire logic        other_busy,     // board busy on another device
  output tape_req_t        tape_req,
  input  wire logic        tape_ack,
  input  wire tape_rsp_t   tape_rsp,
  output logic             erase_before_write,
  output logic             media_watch,
  output logic [7:0]       op_status,
  output logic [95:0]      short_status,
  output logic [95:0]      long_status,
  output logic             intr,
  input  wire logic        sem_clear
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT  = 3'b011,
    ST_POST  = 3'b010,
    ST_HOLD  = 3'b110
  } state_t;

  state_t      state_ff,     nxt_state;
  cmd_t        cmd_ff,       nxt_cmd;
  tape_req_t   req_ff,       nxt_req;
  logic [95:0] short_ff,     nxt_short;
  logic [95:0] long_ff,      nxt_long;
  logic [7:0]  osb_ff,       nxt_osb;
  logic        intr_ff,      nxt_intr;
  logic        sem_ff,       nxt_sem;
  logic        pend_ff,      nxt_pend;
  logic [1:0]  pend_unit_ff, nxt_pend_unit;
  logic        pend_hard_ff, nxt_pend_hard;
  logic        pend_soft_ff, nxt_pend_soft;
  logic        rsp_hard_ff,  nxt_rsp_hard;
  logic        rsp_soft_ff,  nxt_rsp_soft;
  logic        offl_ff,      nxt_offl;
  logic        offl_busy_ff, nxt_offl_busy;

  motion_t     dec_motion;
  logic        dec_offline;
  logic        dec_legal;
  logic [3:0]  pk_sum;
  logic [1:0]  pk_unit;
  logic        pk_hard;
  logic        pk_soft;
  logic [7:0]  pk_osb;
  logic        offl_done;
  logic        load_ack;
  logic [3:0]  watch_vec;

  tape_cmd_decode u_dec (
    .func    (cmd_ff.func),
    .writing (data_write),
    .reading (data_read),
    .motion  (dec_motion),
    .offline (dec_offline),
    .legal   (dec_legal)
  );

  status_byte_pack u_pack (
    .summary  (pk_sum),
    .unit     (pk_unit),
    .hard_err (pk_hard),
    .soft_err (pk_soft),
    .osb      (pk_osb)
  );

  assign cmd_ready          = (state_ff == ST_IDLE);
  assign tape_req           = req_ff;
  assign erase_before_write = data_write;
  assign media_watch        = |watch_vec;
  assign op_status          = osb_ff;
  assign short_status       = short_ff;
  assign long_status        = long_ff;
  assign intr               = intr_ff;

  // completion of a previously handed-over motion, taken in any state
  // so that a finish during a new request's wait is never dropped
  assign offl_done = tape_rsp.done & offl_busy_ff;

  // a load that the drive accepted arms medium watch on that unit only
  assign load_ack = (state_ff == ST_WAIT) & tape_ack & (req_ff.motion == MOT_LOAD_BOT);

  for (genvar u = 0; u < 4; u++) begin : g_watch
    logic watch_unit_ff;
    logic nxt_watch_unit;
    always_comb begin
      nxt_watch_unit = watch_unit_ff;
      if (load_ack && req_ff.unit == 2'(u))
        nxt_watch_unit = 1'b1;
    end
    always_ff @(posedge core_clk) begin
      if (!reset_n)
        watch_unit_ff <= 1'b0;
      else
        watch_unit_ff <= nxt_watch_unit;
    end
    assign watch_vec[u] = watch_unit_ff;
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_cmd       = cmd_ff;
    nxt_req       = req_ff;
    nxt_short     = short_ff;
    nxt_long      = long_ff;
    nxt_osb       = osb_ff;
    nxt_intr      = 1'b0;
    nxt_sem       = sem_ff;
    nxt_pend      = pend_ff;
    nxt_pend_unit = pend_unit_ff;
    nxt_pend_hard = pend_hard_ff;
    nxt_pend_soft = pend_soft_ff;
    nxt_rsp_hard  = rsp_hard_ff;
    nxt_rsp_soft  = rsp_soft_ff;
    nxt_offl      = offl_ff;
    nxt_offl_busy = offl_busy_ff;
    pk_sum        = `SUM_OK;
    pk_unit       = cmd_ff.unit;
    pk_hard       = 1'b0;
    pk_soft       = 1'b0;

    if (sem_clear)
      nxt_sem = 1'b0;

    // off-line finish is latched; the ST_IDLE report clears it unless it is queued behind an older finish
    if (offl_done) begin
      nxt_pend      = 1'b1;
      nxt_offl_busy = 1'b0;
      nxt_pend_unit = tape_rsp.unit;
      nxt_pend_hard = tape_rsp.hard_err;
      nxt_pend_soft = tape_rsp.soft_err;
      nxt_long      = tape_rsp.status;
    end

    case (state_ff)
      ST_IDLE: begin
        if (cmd_start) begin
          nxt_cmd   = cmd;
          nxt_state = ST_ISSUE;
        end else if ((pend_ff | offl_done) && !other_busy && !sem_ff) begin
          // second interrupt is never suppressed
          pk_unit  = pend_ff ? pend_unit_ff : tape_rsp.unit;
          pk_hard  = pend_ff ? pend_hard_ff : tape_rsp.hard_err;
          pk_soft  = pend_ff ? pend_soft_ff : tape_rsp.soft_err;
          pk_sum   = `SUM_OFFLINE;
          nxt_osb  = pk_osb;
          nxt_intr = 1'b1;
          nxt_sem  = 1'b1;
          // a finish arriving while an older one is reported stays queued
          nxt_pend = pend_ff & offl_done;
        end
      end
      ST_ISSUE: begin
        // no drive error carries over from an earlier command
        nxt_rsp_hard = 1'b0;
        nxt_rsp_soft = 1'b0;
        if (!dec_legal || dec_motion == MOT_NONE) begin
          nxt_state = ST_POST;
        end else begin
          nxt_req.valid   = 1'b1;
          nxt_req.motion  = dec_motion;
          nxt_req.unit    = cmd_ff.unit;
          nxt_req.offline = dec_offline;
          nxt_offl        = dec_offline;
          nxt_state       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // ack means started for off-line, finished for short-term
        if (tape_ack) begin
          nxt_req.valid = 1'b0;
          if (req_ff.offline)
            nxt_offl_busy = 1'b1;
          else
            nxt_short = tape_rsp.status;
          // error flags stand only with the ack, so latch them here
          nxt_rsp_hard = tape_rsp.hard_err;
          nxt_rsp_soft = tape_rsp.soft_err;
          nxt_state = ST_POST;
        end
      end
      ST_POST: begin
        pk_sum  = dec_legal ? `SUM_OK : `SUM_BAD_FUNC;
        pk_hard = !dec_legal | (!offl_ff & rsp_hard_ff);
        pk_soft = !offl_ff & rsp_soft_ff;
        nxt_osb = pk_osb;
        nxt_state = ST_HOLD;
      end
      ST_HOLD: begin
        // first interrupt waits for the previous one to be serviced
        if (!sem_ff) begin
          if (!cmd_ff.suppress) begin
            nxt_intr = 1'b1;
            nxt_sem  = 1'b1;
          end
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff     <= ST_IDLE;
      cmd_ff       <= '0;
      req_ff       <= '0;
      short_ff     <= '0;
      long_ff      <= '0;
      osb_ff       <= 8'h00;
      intr_ff      <= 1'b0;
      sem_ff       <= 1'b0;
      pend_ff      <= 1'b0;
      pend_unit_ff <= 2'h0;
      pend_hard_ff <= 1'b0;
      pend_soft_ff <= 1'b0;
      rsp_hard_ff  <= 1'b0;
      rsp_soft_ff  <= 1'b0;
      offl_ff      <= 1'b0;
      offl_busy_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cmd_ff       <= nxt_cmd;
      req_ff       <= nxt_req;
      short_ff     <= nxt_short;
      long_ff      <= nxt_long;
      osb_ff       <= nxt_osb;
      intr_ff      <= nxt_intr;
      sem_ff       <= nxt_sem;
      pend_ff      <= nxt_pend;
      pend_unit_ff <= nxt_pend_unit;
      pend_hard_ff <= nxt_pend_hard;
      pend_soft_ff <= nxt_pend_soft;
      rsp_hard_ff  <= nxt_rsp_hard;
      rsp_soft_ff  <= nxt_rsp_soft;
      offl_ff      <= nxt_offl;
      offl_busy_ff <= nxt_offl_busy;
    end
  end

endmodule : tape_command_sequencer

// ==== bench/tape_seq_chk.sv ====
`timescale 1ns/1ns
module tape_seq_chk
  import tape_seq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire cmd_t        cmd,
  input wire logic        cmd_start,
  input wire logic        cmd_ready,
  input wire tape_req_t   tape_req,
  input wire logic        tape_ack,
  input wire tape_rsp_t   tape_rsp,
  input wire logic        media_watch,
  input wire logic [7:0]  op_status,
  input wire logic [95:0] long_status,
  input wire logic        intr,
  input wire logic        sem_clear
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  logic sem_ff;
  logic nxt_sem;
  logic take;
  assign take = cmd_start && cmd_ready;
  // the design sets its semaphore with the pulse, so a clear seen during
  // the pulse already frees the next report
  always_comb begin
    nxt_sem = !reset_n ? 1'b0 : sem_clear ? 1'b0 : intr ? 1'b1 : sem_ff;
  end
  always_ff @(posedge core_clk) begin
    sem_ff <= nxt_sem;
  end
  property maps(logic [7:0] f, motion_t m);
    take && cmd.func == f |-> ##[2:3] tape_req.valid && tape_req.motion == m;
  endproperty
  space_map_a: assert property (maps(8'h12, MOT_SPACE_FM)) else $error("bad motion");
  erase_map_a: assert property (maps(8'h17, MOT_ERASE)) else $error("bad motion");
  offline_kind_a: assert property (tape_req.valid |-> tape_req.offline ==
    (tape_req.motion inside {MOT_SPACE_FM, MOT_ERASE, MOT_RETENSION})) else $error("bad kind");
  req_hold_a: assert property (tape_req.valid && !tape_ack |=> $stable(tape_req))
    else $error("request dropped");
  watch_keep_a: assert property (media_watch |=> media_watch) else $error("watch lost");
  long_post_a: assert property (tape_rsp.done |=> long_status == $past(tape_rsp.status))
    else $error("long status");
  sem_block_a: assert property (intr |-> !sem_ff) else $error("intr while held");
  intr_pulse_a: assert property (intr |=> !intr) else $error("intr too long");
  bad_func_a: assert property (take && cmd.func > 8'h1f |-> ##1
    (!tape_req.valid)[*3] ##[0:3] (op_status[7:6] == 2'b11 && op_status[3:0] == 4'h1))
    else $error("bad function");
  cover property (take && cmd.suppress);
  cover property (tape_rsp.done);
  cover property (intr && op_status[3:0] == 4'h2);
endmodule : tape_seq_chk

bind tape_command_sequencer tape_seq_chk chk (
  .core_clk(core_clk), .reset_n(reset_n), .cmd(cmd), .cmd_start(cmd_start),
  .cmd_ready(cmd_ready), .tape_req(tape_req), .tape_ack(tape_ack), .tape_rsp(tape_rsp),
  .media_watch(media_watch), .op_status(op_status), .long_status(long_status),
  .intr(intr), .sem_clear(sem_clear)
);

// ==== bench/tape_drive_model.sv ====
`timescale 1ns/1ns
module tape_drive_model
  import tape_seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire tape_req_t   tape_req,
  input  wire logic [3:0]  ack_dly,
  input  wire logic [7:0]  done_dly,
  input  wire logic [95:0] stat,
  output tape_rsp_t        tape_rsp,
  output logic             tape_ack
);
  int   cnt = 0;
  int   dcnt = 0;
  logic busy = 1'b0;
  initial tape_ack = 1'b0;
  initial tape_rsp = '0;
  // waits for valid to drop, so a late release is not taken as a new request
  always @(negedge core_clk) begin
    tape_ack <= 1'b0;
    tape_rsp.done <= 1'b0;
    tape_rsp.status <= ~tape_rsp.status;
    if (dcnt == 1) begin
      tape_rsp.done <= 1'b1;
      tape_rsp.status <= stat;
      // top status bits double as the drive's error flags
      tape_rsp.hard_err <= stat[95];
      tape_rsp.soft_err <= stat[94];
    end
    if (dcnt > 0) dcnt <= dcnt - 1;
    if (!tape_req.valid) busy <= 1'b0;
    else if (!busy) cnt <= cnt + 1;
    if (tape_req.valid && !busy && cnt >= ack_dly) begin
      tape_ack <= 1'b1;
      tape_rsp.status <= stat;
      tape_rsp.unit <= tape_req.unit;
      tape_rsp.hard_err <= stat[95];
      tape_rsp.soft_err <= stat[94];
      busy <= 1'b1;
      cnt <= 0;
      if (tape_req.offline) dcnt <= done_dly;
    end
  end
endmodule : tape_drive_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import tape_seq_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  cmd_t        cmd = '0;
  logic        cmd_start = 1'b0;
  logic        data_write = 1'b0;
  logic        data_read = 1'b0;
  logic        other_busy = 1'b0;
  logic        sem_clear = 1'b0;
  logic [3:0]  ack_dly = 4'h0;
  logic [7:0]  done_dly = 8'h0a;
  logic [95:0] stat = '0;
  logic        cmd_ready, tape_ack, erase_before_write, media_watch, intr, got, off;
  tape_req_t   tape_req;
  tape_rsp_t   tape_rsp;
  logic [7:0]  op_status;
  logic [95:0] short_status, long_status;
  motion_t     last_mot = MOT_NONE;
  int          seed = 32'h8628;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  codes [7] = '{8'h1c, 8'h18, 8'h12, 8'h14, 8'h17, 8'h1d, 8'h1e};

  tape_command_sequencer uut (
    .core_clk(core_clk), .reset_n(reset_n), .cmd(cmd), .cmd_start(cmd_start),
    .cmd_ready(cmd_ready), .data_write(data_write), .data_read(data_read),
    .other_busy(other_busy), .tape_req(tape_req), .tape_ack(tape_ack),
    .tape_rsp(tape_rsp), .erase_before_write(erase_before_write),
    .media_watch(media_watch), .op_status(op_status), .short_status(short_status),
    .long_status(long_status), .intr(intr), .sem_clear(sem_clear)
  );
  tape_drive_model far_end (
    .core_clk(core_clk), .tape_req(tape_req), .ack_dly(ack_dly), .done_dly(done_dly),
    .stat(stat), .tape_rsp(tape_rsp), .tape_ack(tape_ack)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (tape_req.valid === 1'b1) last_mot <= tape_req.motion;
    if (cycles == 8000) begin
      mismatches++;
      end_of_test();
    end
  end

  function automatic motion_t exp_mot(logic [7:0] f);
    case (f)
      8'h12: return MOT_SPACE_FM;
      8'h14: return MOT_WRITE_FM;
      8'h17: return MOT_ERASE;
      8'h18: return MOT_LOAD_BOT;
      8'h1c: return MOT_INIT;
      8'h1d: return MOT_RETENSION;
      8'h1e: return MOT_STATUS;
      8'h1f: return data_write ? MOT_WRITE_FM : data_read ? MOT_REWIND : MOT_NONE;
      default: return MOT_NONE;
    endcase
  endfunction : exp_mot

  // drive errors ride on the status word; off-line first reports carry none
  function automatic logic [7:0] exp_osb(logic [3:0] sum, logic errs);
    logic [1:0] e;
    e = errs ? {stat[95] | stat[94], stat[95]} : 2'b00;
    return {e, cmd.unit, sum};
  endfunction : exp_osb

  task automatic chk(logic [95:0] g, logic [95:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic issue(logic [7:0] f, logic sup);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    last_mot = MOT_NONE;
    ack_dly = 4'($random(seed));
    stat = {$random(seed), $random(seed), $random(seed)};
    cmd = '{16'($random(seed)), 2'($random(seed)), f, sup};
    cmd_start = 1'b1;
    @(negedge core_clk);
    cmd_start = 1'b0;
  endtask : issue

  task automatic wait_intr(int n);
    got = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      if (intr === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask : wait_intr

  task automatic clr_sem();
    sem_clear = 1'b1;
    @(negedge core_clk);
    sem_clear = 1'b0;
  endtask : clr_sem

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    foreach (codes[i]) begin
      done_dly = 8'd12 + 8'($random(seed) & 31);
      off = codes[i] inside {8'h12, 8'h17, 8'h1d};
      issue(codes[i], 1'b0);
      wait_intr(60);
      chk({got, op_status}, {1'b1, exp_osb(4'h0, !off)});
      chk(last_mot, exp_mot(codes[i]));
      clr_sem();
      if (off) begin
        wait_intr(80);
        chk({got, op_status}, {1'b1, exp_osb(4'h2, 1'b1)});
        chk(long_status, stat);
        clr_sem();
      end else begin
        chk(short_status, stat);
      end
    end
    chk(media_watch, 1'b1);
    $display("test sweep done");
    done_dly = 8'd100;
    issue(8'h17, 1'b1);
    wait_intr(40);
    chk(got, 1'b0);
    wait_intr(120);
    chk({got, op_status[3:0]}, {1'b1, 4'h2});
    clr_sem();
    $display("test suppress done");
    done_dly = 8'd10;
    issue(8'h12, 1'b0);
    wait_intr(40);
    wait_intr(60);
    chk(got, 1'b0);
    other_busy = 1'b1;
    clr_sem();
    wait_intr(20);
    chk(got, 1'b0);
    other_busy = 1'b0;
    wait_intr(10);
    chk({got, op_status[3:0]}, {1'b1, 4'h2});
    clr_sem();
    $display("test deferred done");
    issue(8'h20, 1'b0);
    wait_intr(40);
    chk({got, op_status}, {1'b1, 2'b11, cmd.unit, 4'h1});
    chk(last_mot, MOT_NONE);
    clr_sem();
    for (int k = 0; k < 3; k++) begin
      data_write = (k == 1);
      data_read = (k == 2);
      issue(8'h1f, 1'b0);
      chk(erase_before_write, data_write);
      wait_intr(60);
      chk({got, op_status}, {1'b1, exp_osb(4'h0, k != 0)});
      chk(last_mot, exp_mot(8'h1f));
      clr_sem();
    end
    $display("test terminate done");
    end_of_test();
  end
endmodule : tb_top
